// ===== agucb_core.sv
// Purpose: effective address generation with circular and bit-reversed
//   modification, plus program-space address forming
// Assumes: one request of each kind per cycle, results one cycle later
// Notes: program read data is returned one cycle after prog_rvalid
//
// Implementation choices: the strobed register port and the placing of the registers.
module agucb_core
  import agucb_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // address requests from execution
  input  agucb_req_s       req,
  output agucb_res_s       res,
  input  agucb_tbl_s       tbl,
  // program memory port
  output agucb_prog_s      prog,
  input  wire logic        prog_rvalid,
  input  wire logic [23:0] prog_rdata,
  output logic             rd_valid,
  output logic      [15:0] rd_data,
  output logic             window_wr_blocked
);
  // ****************************************
  // registers
  // ****************************************
  logic [15:0] regs [REG_COUNT];
  logic [15:0] status;
  logic [15:0] next_rdata;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int k = 0; k < REG_COUNT; k++) begin
        regs[k] <= REG_RESET;
      end
    end else if (reg_wr && reg_addr < REG_STATUS) begin
      if (reg_addr == REG_TBL_PAGE || reg_addr == REG_VIS_PAGE) begin
        regs[reg_addr] <= reg_wdata & MASK_PAGE;
      end else begin
        regs[reg_addr] <= reg_wdata & MASK_FULL;
      end
    end
  end

  always_comb begin
    next_rdata = 16'h0000;
    if (reg_addr < REG_STATUS) begin
      next_rdata = regs[reg_addr];
    end else if (reg_addr == REG_STATUS) begin
      next_rdata = status;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= reg_rd ? next_rdata : 16'h0000;
    end
  end

  logic [15:0] circ_ctrl;
  logic [14:0] pivot;
  logic [7:0]  tbl_page;
  logic [7:0]  vis_page;
  logic        bit_reverse_enable;
  logic        program_window_enable;
  logic [3:0]  x_sel;
  logic [3:0]  y_sel;
  logic [3:0]  b_sel;
  assign circ_ctrl = regs[REG_CIRC_CTRL];
  assign pivot = regs[REG_BREV_CTRL][14:0];
  assign bit_reverse_enable = regs[REG_BREV_CTRL][REV_EN_BIT];
  assign tbl_page = regs[REG_TBL_PAGE][7:0];
  assign vis_page = regs[REG_VIS_PAGE][7:0];
  assign program_window_enable = regs[REG_CORE_CTRL][PWE_BIT];
  assign x_sel = circ_ctrl[XSEL_LSB+:4];
  assign y_sel = circ_ctrl[YSEL_LSB+:4];
  assign b_sel = circ_ctrl[BSEL_LSB+:4];

  // ****************************************
  // mode decode
  // ****************************************
  logic is_inc;
  logic is_pre;
  logic is_post;
  logic is_ofs;
  logic brev_on;
  logic brev_act;
  logic circ_on;
  assign is_inc = req.mode == MODE_PRE_INC || req.mode == MODE_POST_INC;
  assign is_pre = req.mode == MODE_PRE_INC || req.mode == MODE_PRE_DEC;
  assign is_post = req.mode == MODE_POST_INC || req.mode == MODE_POST_DEC;
  assign is_ofs = req.mode == MODE_REG_OFS || req.mode == MODE_LIT_OFS;
  assign brev_on = b_sel != SEL_NONE && bit_reverse_enable;
  assign brev_act = brev_on && req.ptr_sel == b_sel && is_inc
                    && req.unit == UNIT_XW && !req.byte_acc;

  always_comb begin
    circ_on = 1'b0;
    if (req.unit == UNIT_Y) begin
      circ_on = y_sel != SEL_NONE && circ_ctrl[Y_EN_BIT]
                && req.ptr_sel == y_sel && !brev_on;
    end else begin
      circ_on = x_sel != SEL_NONE && circ_ctrl[X_EN_BIT]
                && req.ptr_sel == x_sel
                && !(req.unit == UNIT_XW && brev_act);
    end
  end

  // ****************************************
  // circular correction
  // ****************************************
  logic [15:0] b_start;
  logic [15:0] b_end;
  logic [15:0] b_len;
  logic [15:0] mod_new;
  logic        dir_up;
  logic [15:0] circ_new;
  logic        hit;
  assign b_start = req.unit == UNIT_Y ? regs[REG_Y_START] : regs[REG_X_START];
  assign b_end = req.unit == UNIT_Y ? regs[REG_Y_END] : regs[REG_X_END];
  assign b_len = 16'(b_end - b_start + 16'h0001);
  assign dir_up = is_inc || (is_ofs && !req.ofs[15]);

  always_comb begin
    mod_new = req.ptr;
    if (is_inc || is_ofs) begin
      mod_new = 16'(req.ptr + req.ofs);
    end else if (req.mode != MODE_IND) begin
      mod_new = 16'(req.ptr - req.ofs);
    end
  end

  always_comb begin
    circ_new = mod_new;
    hit = 1'b0;
    if (circ_on && req.mode != MODE_IND) begin
      if (dir_up && mod_new > b_end) begin
        hit = 1'b1;
        circ_new = 16'(mod_new - b_len);
      end else if (!dir_up && mod_new < b_start) begin
        hit = 1'b1;
        circ_new = 16'(mod_new + b_len);
      end
    end
  end

  // ****************************************
  // reverse-carry update
  // ****************************************
  logic [14:0] ptr_rev;
  logic [14:0] piv_rev;
  logic [14:0] sum_rev;
  logic [15:0] brv_new;
  assign brv_new[0] = 1'b0;
  assign sum_rev = 15'(ptr_rev + piv_rev);
  for (genvar i = 0; i < 15; i++) begin : g_rev
    assign ptr_rev[i] = req.ptr[15-i];
    assign piv_rev[i] = pivot[14-i];
    assign brv_new[1+i] = sum_rev[14-i];
  end

  // ****************************************
  // result
  // ****************************************
  agucb_res_s next_res;
  logic [15:0] upd;
  always_comb begin
    upd = brev_act ? brv_new : circ_new;
    if (req.unit == UNIT_Y) begin
      upd[0] = 1'b0;
    end
    next_res.valid = req.valid;
    next_res.wb_en = req.valid && (is_pre || is_post);
    next_res.wb_ptr = upd;
    next_res.ea = is_post ? req.ptr : upd;
    if (req.unit == UNIT_Y) begin
      next_res.ea[0] = 1'b0;
    end
    next_res.circ_hit = req.valid && hit && !brev_act;
    next_res.brev_act = req.valid && brev_act;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      res <= '0;
    end else begin
      res <= next_res;
    end
  end

  // ****************************************
  // program space addressing
  // ****************************************
  agucb_prog_s next_prog;
  logic win_hit;
  logic next_blk;
  assign win_hit = req.valid && program_window_enable
                   && next_res.ea[15] && !tbl.valid;

  always_comb begin
    next_prog = '0;
    next_blk = 1'b0;
    if (tbl.valid) begin
      next_prog.valid = 1'b1;
      next_prog.wr = tbl.wr;
      next_prog.addr = {tbl_page, tbl.ea};
      next_prog.cfg = tbl_page[CFG_BIT];
      if (tbl.hi) begin
        next_prog.wstrb = 3'h4;
        next_prog.wdata = {tbl.wdata[7:0], 16'h0000};
      end else if (tbl.byte_acc) begin
        next_prog.wstrb = tbl.ea[0] ? 3'h2 : 3'h1;
        next_prog.wdata = {8'h00, tbl.wdata[7:0], tbl.wdata[7:0]};
      end else begin
        next_prog.wstrb = 3'h3;
        next_prog.wdata = {8'h00, tbl.wdata};
      end
      next_prog.wstrb = tbl.wr ? next_prog.wstrb : 3'h0;
    end else if (win_hit && req.unit == UNIT_XW) begin
      next_blk = 1'b1;
    end else if (win_hit) begin
      next_prog.valid = 1'b1;
      next_prog.addr = {1'b0, vis_page, next_res.ea[14:0]};
    end
  end

  // read kind held until the memory answers: 0 low word, 1 high byte
  logic rd_hi;
  logic rd_byte;
  logic rd_odd;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prog <= '0;
      window_wr_blocked <= 1'b0;
      rd_hi <= 1'b0;
      rd_byte <= 1'b0;
      rd_odd <= 1'b0;
    end else begin
      prog <= next_prog;
      window_wr_blocked <= next_blk;
      if (next_prog.valid && !next_prog.wr) begin
        rd_hi <= tbl.valid && tbl.hi;
        rd_byte <= tbl.valid && tbl.byte_acc;
        rd_odd <= tbl.ea[0];
      end
    end
  end

  logic [15:0] next_rd;
  always_comb begin
    next_rd = prog_rdata[15:0];
    if (rd_hi) begin
      next_rd = (rd_byte && rd_odd) ? 16'h0000 : {8'h00, prog_rdata[23:16]};
    end else if (rd_byte) begin
      next_rd = {8'h00, rd_odd ? prog_rdata[15:8] : prog_rdata[7:0]};
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_valid <= 1'b0;
      rd_data <= 16'h0000;
    end else begin
      rd_valid <= prog_rvalid;
      rd_data <= prog_rvalid ? next_rd : 16'h0000;
    end
  end

  // sticky status, set wins over the clearing write
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      status <= 16'h0000;
    end else begin
      status <= ((reg_wr && reg_addr == REG_STATUS) ? status & ~reg_wdata : status)
                | {12'h000, next_blk, win_hit, next_res.brev_act, next_res.circ_hit};
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_tbl_issue;
    tbl.valid && !tbl.wr;
  endsequence
  sequence s_tbl_addr;
    prog.valid && prog.addr == {$past(tbl_page), $past(tbl.ea)};
  endsequence

  a_tbl_addr_form: assert property (s_tbl_issue |=> s_tbl_addr)
    else $error("table address not page over ea");
  a_tbl_cfg_space: assert property (tbl.valid |=> prog.cfg == prog.addr[23])
    else $error("configuration select mismatch");
  a_win_addr_form: assert property (win_hit && !tbl.valid && req.unit != UNIT_XW
    |=> prog.addr == {1'b0, $past(vis_page), $past(next_res.ea[14:0])})
    else $error("mapped address wrong");
  a_win_no_write: assert property (prog.valid && !$past(tbl.valid) |-> !prog.wr)
    else $error("mapped window written");
  a_brev_lsb_clr: assert property (res.brev_act |-> res.wb_ptr[0] == 1'b0)
    else $error("reversed address odd");
  a_brev_mirror: assert property (brev_act && pivot == 15'h0008
    && req.ptr[4:1] == 4'h8 |=> res.wb_ptr[4:1] == 4'h4)
    else $error("reversed index not mirrored");
  a_ofs_no_wb: assert property (req.valid && is_ofs |=> !res.wb_en)
    else $error("offset mode wrote pointer");
  a_y_lsb_clr: assert property (req.valid && req.unit == UNIT_Y
    |=> res.ea[0] == 1'b0 && res.wb_ptr[0] == 1'b0)
    else $error("y address odd");
  a_circ_up_wrap: assert property (circ_on && is_inc && !brev_act
    && mod_new > b_end
    |=> res.wb_ptr == $past(mod_new) - $past(b_end) + $past(b_start) - 16'h0001)
    else $error("upper wrap wrong");
  a_brev_no_byte: assert property (req.byte_acc |=> !res.brev_act)
    else $error("reversal on byte access");
endmodule

// ===== agucb_pkg.sv
// Purpose: constants and carriers for the address generation block
// Assumes: 16-bit data space, 24-bit program space, word offsets in bytes
// Notes: register offsets are word indexes on the plain register port
package agucb_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [3:0] REG_CIRC_CTRL = 4'h0;
  localparam logic [3:0] REG_BREV_CTRL = 4'h1;
  localparam logic [3:0] REG_TBL_PAGE  = 4'h2;
  localparam logic [3:0] REG_VIS_PAGE  = 4'h3;
  localparam logic [3:0] REG_CORE_CTRL = 4'h4;
  localparam logic [3:0] REG_X_START   = 4'h5;
  localparam logic [3:0] REG_X_END     = 4'h6;
  localparam logic [3:0] REG_Y_START   = 4'h7;
  localparam logic [3:0] REG_Y_END     = 4'h8;
  localparam logic [3:0] REG_STATUS    = 4'h9;
  localparam int         REG_COUNT     = 9;
  localparam logic [15:0] REG_RESET    = 16'h0000;
  localparam logic [15:0] MASK_PAGE    = 16'h00ff;
  localparam logic [15:0] MASK_FULL    = 16'hffff;
  // ****************************************
  // field positions
  // ****************************************
  localparam int         X_EN_BIT  = 15;
  localparam int         Y_EN_BIT  = 14;
  localparam int         XSEL_LSB  = 0;
  localparam int         YSEL_LSB  = 4;
  localparam int         BSEL_LSB  = 8;
  localparam int         REV_EN_BIT = 15;
  localparam int         PWE_BIT   = 2;
  localparam int         CFG_BIT   = 7;
  localparam logic [3:0] SEL_NONE  = 4'hf;
  // ****************************************
  // carriers
  // ****************************************
  typedef enum logic [2:0] {
    MODE_IND  = 3'h0, MODE_POST_INC = 3'h1, MODE_POST_DEC = 3'h2,
    MODE_PRE_INC = 3'h3, MODE_PRE_DEC = 3'h4, MODE_REG_OFS = 3'h5,
    MODE_LIT_OFS = 3'h6
  } agucb_mode_e;
  typedef enum logic [1:0] {
    UNIT_XR = 2'h0, UNIT_XW = 2'h1, UNIT_Y = 2'h2
  } agucb_unit_e;
  typedef struct packed {
    logic        valid;
    agucb_unit_e unit;
    agucb_mode_e mode;
    logic [3:0]  ptr_sel;
    logic [15:0] ptr;
    logic [15:0] ofs;
    logic        byte_acc;
  } agucb_req_s;
  typedef struct packed {
    logic        valid;
    logic [15:0] ea;
    logic        wb_en;
    logic [15:0] wb_ptr;
    logic        circ_hit;
    logic        brev_act;
  } agucb_res_s;
  typedef struct packed {
    logic        valid;
    logic        wr;
    logic        hi;
    logic        byte_acc;
    logic [15:0] ea;
    logic [15:0] wdata;
  } agucb_tbl_s;
  typedef struct packed {
    logic        valid;
    logic        wr;
    logic        cfg;
    logic [2:0]  wstrb;
    logic [23:0] addr;
    logic [23:0] wdata;
  } agucb_prog_s;
endpackage

// ===== agucb_mem_model.sv
// Purpose: program memory seen by the address block, answers reads
// Assumes: one read outstanding, answer after 0 or 3 idle cycles
// Notes: read data lines toggle while no answer is presented
module agucb_mem_model
  import agucb_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // program memory port
  input  agucb_prog_s      prog,
  input  wire logic        slow,
  output logic             prog_rvalid,
  output logic      [23:0] prog_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [23:0] word;
  logic [1:0]  hold;
  logic        pend;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pend        <= 1'b0;
      hold        <= 2'h0;
      word        <= 24'h000000;
      prog_rvalid <= 1'b0;
      prog_rdata  <= 24'h000000;
    end else begin
      prog_rvalid <= 1'b0;
      prog_rdata  <= ~prog_rdata;
      if (prog.valid && !prog.wr) begin
        pend <= 1'b1;
        word <= {prog.addr[7:0] ^ 8'ha5, prog.addr[15:0]};
        hold <= slow ? 2'h3 : 2'h0;
      end else if (pend && hold != 2'h0) begin
        hold <= hold - 2'h1;
      end else if (pend) begin
        pend        <= 1'b0;
        prog_rvalid <= 1'b1;
        prog_rdata  <= word;
      end
    end
  end
endmodule

// ===== agucb_core_test.sv
// Purpose: self-checking bench for the address generation block
// Assumes: register writes act on the next cycle, results one cycle on
// Notes: random offsets, table addresses and pages come from a seeded lfsr
module agucb_core_test
  import agucb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk, rst_n, reg_wr, reg_rd, prog_rvalid, rd_valid, window_wr_blocked, slow;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rd_data, lf, p, e;
  logic [7:0]  pg;
  logic [23:0] prog_rdata;
  agucb_req_s  req;
  agucb_res_s  res;
  agucb_tbl_s  tbl;
  agucb_prog_s prog;
  int          num_errors, n_tests;

  agucb_core dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .req(req), .res(res),
    .tbl(tbl), .prog(prog), .prog_rvalid(prog_rvalid), .prog_rdata(prog_rdata),
    .rd_valid(rd_valid), .rd_data(rd_data), .window_wr_blocked(window_wr_blocked));
  agucb_mem_model mem (.mclk(mclk), .rst_n(rst_n), .prog(prog), .slow(slow),
    .prog_rvalid(prog_rvalid), .prog_rdata(prog_rdata));

  // ****************************************
  // expectation helpers
  // ****************************************
  function automatic logic [15:0] rev(input logic [15:0] v);
    for (int i = 0; i < 16; i++) rev[i] = v[15-i];
  endfunction
  function automatic logic [15:0] brsum(input logic [15:0] a, input logic [14:0] pv);
    return rev(rev(a) + rev({pv, 1'b0})) & 16'hfffe;
  endfunction
  // read data as the memory word {addr[7:0]^a5, addr[15:0]} is steered
  function automatic logic [15:0] rdx(input logic [23:0] a, input logic h, input logic y);
    if (h) return (y && a[0]) ? 16'h0000 : {8'h00, a[7:0] ^ 8'ha5};
    if (y) return {8'h00, a[0] ? a[15:8] : a[7:0]};
    return a[15:0];
  endfunction
  function automatic logic [15:0] nxt(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] x);
    @(posedge mclk);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", 24'(reg_rdata), 24'(x));
  endtask
  task automatic op(input agucb_unit_e u, input agucb_mode_e m, input logic [3:0] s,
                    input logic [15:0] a, input logic [15:0] o, input logic b);
    @(posedge mclk);
    req <= '{1'b1, u, m, s, a, o, b};
    @(posedge mclk);
    req <= '0;
    #1;
  endtask
  task automatic tb(input logic w, input logic h, input logic y, input logic [15:0] a);
    @(posedge mclk);
    tbl <= '{1'b1, w, h, y, a, ~a};
    @(posedge mclk);
    tbl <= '0;
    #1;
  endtask
  task automatic rc(input logic [15:0] ea, input logic wb, input logic [15:0] wp, input logic br);
    chk("res_valid", 24'(res.valid), 24'h1);
    chk("res_ea", 24'(res.ea), 24'(ea));
    chk("wb_en", 24'(res.wb_en), 24'(wb));
    if (wb) chk("wb_ptr", 24'(res.wb_ptr), 24'(wp));
    chk("brev_act", 24'(res.brev_act), 24'(br));
  endtask
  task automatic pc(input logic v, input logic w, input logic c, input logic [23:0] a);
    chk("prog_valid", 24'(prog.valid), 24'(v));
    if (v) chk("prog", {prog.wr, prog.cfg, prog.addr[21:0]}, {w, c, a[21:0]});
    if (v) chk("prog_hi", 24'(prog.addr[23:22]), 24'(a[23:22]));
  endtask
  task automatic rdw(input logic [23:0] a, input logic h, input logic y);
    int k;
    k = 0;
    while (rd_valid !== 1'b1 && k < 20) begin
      @(posedge mclk);
      #1 k++;
    end
    chk("rd_valid", 24'(rd_valid), 24'h1);
    chk("rd_data", 24'(rd_data), 24'(rdx(a, h, y)));
  endtask
  task automatic report_and_stop;
    if (num_errors == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    report_and_stop;
  end

  initial begin
    rst_n = 1'b0; req = '0; tbl = '0; reg_wr = 1'b0; reg_rd = 1'b0; slow = 1'b0;
    reg_addr = 4'h0; reg_wdata = 16'h0000; lf = 16'd4506; num_errors = 0; n_tests = 0;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    rd(REG_CIRC_CTRL, REG_RESET);
    wr(REG_TBL_PAGE, 16'h01ab);
    rd(REG_TBL_PAGE, 16'h00ab);
    rd(4'ha, 16'h0000);
    // circular buffer 0x1100..0x11ff on pointer 3
    wr(REG_X_START, 16'h1100);
    wr(REG_X_END, 16'h11ff);
    wr(REG_CIRC_CTRL, 16'h82f3);
    op(UNIT_XR, MODE_PRE_INC, 4'h3, 16'h11fe, 16'h0002, 1'b0);
    rc(16'h1100, 1'b1, 16'h1100, 1'b0);
    chk("circ_hit", 24'(res.circ_hit), 24'h1);
    op(UNIT_XR, MODE_POST_INC, 4'h3, 16'h11fe, 16'h0006, 1'b0);
    rc(16'h11fe, 1'b1, 16'h1104, 1'b0);
    op(UNIT_XR, MODE_PRE_DEC, 4'h3, 16'h1100, 16'h0002, 1'b0);
    rc(16'h11fe, 1'b1, 16'h11fe, 1'b0);
    op(UNIT_XR, MODE_REG_OFS, 4'h3, 16'h11fe, 16'h0004, 1'b0);
    rc(16'h1102, 1'b0, 16'h0000, 1'b0);
    op(UNIT_XR, MODE_LIT_OFS, 4'h3, 16'h1100, 16'hfffc, 1'b0);
    rc(16'h11fc, 1'b0, 16'h0000, 1'b0);
    op(UNIT_XR, MODE_PRE_INC, 4'h4, 16'h11fe, 16'h0002, 1'b0);
    rc(16'h1200, 1'b1, 16'h1200, 1'b0);
    // reversed walk on pointer 2, 16 words from an aligned start
    wr(REG_Y_START, 16'h1100);
    wr(REG_Y_END, 16'h11ff);
    wr(REG_CIRC_CTRL, 16'hc233);
    wr(REG_BREV_CTRL, 16'h8008);
    p = 16'h0800;
    for (int i = 0; i < 16; i++) begin
      lf = nxt(lf);
      e = brsum(p, 15'h0008);
      chk("mirror", 24'(p[4:1]), 24'({i[0], i[1], i[2], i[3]}));
      op(UNIT_XW, i[0] ? MODE_PRE_INC : MODE_POST_INC, 4'h2, p, lf, 1'b0);
      rc(i[0] ? e : p, 1'b1, e, 1'b1);
      p = e;
    end
    op(UNIT_XW, MODE_POST_INC, 4'h2, 16'h0800, 16'h0001, 1'b1);
    rc(16'h0800, 1'b1, 16'h0801, 1'b0);
    op(UNIT_XW, MODE_POST_DEC, 4'h2, 16'h0800, 16'h0002, 1'b0);
    rc(16'h0800, 1'b1, 16'h07fe, 1'b0);
    op(UNIT_XR, MODE_POST_INC, 4'h2, 16'h0800, 16'h0002, 1'b0);
    rc(16'h0800, 1'b1, 16'h0802, 1'b0);
    op(UNIT_XR, MODE_PRE_INC, 4'h3, 16'h11fe, 16'h0002, 1'b0);
    rc(16'h1100, 1'b1, 16'h1100, 1'b0);
    op(UNIT_Y, MODE_PRE_INC, 4'h3, 16'h11fe, 16'h0002, 1'b0);
    rc(16'h1200, 1'b1, 16'h1200, 1'b0);
    wr(REG_BREV_CTRL, 16'h0008);
    op(UNIT_Y, MODE_PRE_INC, 4'h3, 16'h11fe, 16'h0002, 1'b0);
    rc(16'h1100, 1'b1, 16'h1100, 1'b0);
    // table access, fixed then random pages and addresses
    wr(REG_TBL_PAGE, 16'h0080);
    tb(1'b0, 1'b0, 1'b0, 16'h1234);
    pc(1'b1, 1'b0, 1'b1, 24'h801234);
    rdw(24'h801234, 1'b0, 1'b0);
    tb(1'b0, 1'b0, 1'b1, 16'h1235);
    rdw(24'h801235, 1'b0, 1'b1);
    tb(1'b0, 1'b1, 1'b1, 16'h1235);
    rdw(24'h801235, 1'b1, 1'b1);
    for (int i = 0; i < 8; i++) begin
      lf = nxt(lf);
      pg = lf[7:0];
      wr(REG_TBL_PAGE, lf);
      lf = nxt(lf);
      slow <= lf[1];
      tb(1'b0, lf[0], lf[2], lf);
      pc(1'b1, 1'b0, pg[7], {pg, lf});
      rdw({pg, lf}, lf[0], lf[2]);
    end
    tb(1'b1, 1'b1, 1'b0, 16'h0010);
    chk("wstrb", 24'(prog.wstrb), 24'h4);
    chk("wdata", prog.wdata, 24'hef0000);
    tb(1'b1, 1'b0, 1'b0, 16'h0010);
    chk("wstrb", 24'(prog.wstrb), 24'h3);
    chk("wdata", prog.wdata, 24'h00ffef);
    tb(1'b1, 1'b0, 1'b1, 16'h0011);
    chk("wstrb", 24'(prog.wstrb), 24'h2);
    chk("wdata", prog.wdata, 24'h00eeee);
    // mapped window
    wr(REG_VIS_PAGE, 16'h0005);
    op(UNIT_XR, MODE_IND, 4'h0, 16'h9234, 16'h0000, 1'b0);
    pc(1'b0, 1'b0, 1'b0, 24'h0);
    wr(REG_CORE_CTRL, 16'h0004);
    op(UNIT_XR, MODE_IND, 4'h0, 16'h9234, 16'h0000, 1'b0);
    pc(1'b1, 1'b0, 1'b0, 24'h029234);
    rdw(24'h029234, 1'b0, 1'b0);
    op(UNIT_XR, MODE_IND, 4'h0, 16'h1234, 16'h0000, 1'b0);
    pc(1'b0, 1'b0, 1'b0, 24'h0);
    op(UNIT_XW, MODE_IND, 4'h0, 16'h9234, 16'h0000, 1'b0);
    pc(1'b0, 1'b0, 1'b0, 24'h0);
    chk("window_wr_blocked", 24'(window_wr_blocked), 24'h1);
    rd(REG_STATUS, 16'h000f);
    wr(REG_STATUS, 16'h0005);
    rd(REG_STATUS, 16'h000a);
    report_and_stop;
  end
endmodule
